// [hdl/erase_seq_pkg.sv]
/*
  Package for the serial flash erase sequencer: opcodes, address field
  positions, timing figures and the shared link and erase-request structs.
  Assumes a 25 MHz core clock; figures below are in nanoseconds or cycles.
*/
package erase_seq_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS           = 40;
  localparam int unsigned BLOCK_ERASE_TIME_NS     = 20000;
  localparam int unsigned SECTOR_ERASE_TIME_NS    = 40000;
  localparam int unsigned WHOLE_ARRAY_ERASE_TIME_NS = 80000;
  localparam int unsigned BLOCK_ERASE_CYCLES      = BLOCK_ERASE_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned SECTOR_ERASE_CYCLES     = SECTOR_ERASE_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned WHOLE_ARRAY_ERASE_CYCLES = WHOLE_ARRAY_ERASE_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned TIMER_WIDTH             = 24;

  // ****************************************************************
  // Command bytes
  // ****************************************************************
  localparam logic [7:0] OP_BLOCK_ERASE  = 8'h50;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h7C;
  localparam logic [7:0] CHIP_ERASE_B0   = 8'hC7;
  localparam logic [7:0] CHIP_ERASE_B1   = 8'h94;
  localparam logic [7:0] CHIP_ERASE_B2   = 8'h80;
  localparam logic [7:0] CHIP_ERASE_B3   = 8'h9A;
  localparam int unsigned ADDR_BYTES     = 3;
  localparam int unsigned CHIP_ERASE_BYTES = 4;

  // ****************************************************************
  // Address layout (24-bit address field, bit 23 first on the wire)
  // ****************************************************************
  // Standard: 1 ignored bit, page bits 12..0 at 22..10
  localparam int unsigned STD_PAGE_LSB   = 10;
  // Binary: 2 ignored bits, byte address 21..9 at 21..9
  localparam int unsigned BIN_PAGE_LSB   = 9;
  localparam int unsigned PAGE_BITS      = 13;
  localparam int unsigned BLOCK_LSB      = 3;
  localparam int unsigned BLOCK_BITS     = 10;
  localparam int unsigned SECTOR_LSB     = 7;
  localparam int unsigned SECTOR_BITS    = 6;
  localparam int unsigned SUB_SECTOR_BIT = 3;
  localparam int unsigned PAGES_PER_BLOCK = 8;
  localparam int unsigned NUM_SECTORS    = 64;
  localparam logic [7:0]  ERASED_BYTE    = 8'hFF;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    ERASE_NONE,
    ERASE_BLOCK,
    ERASE_SECTOR,
    ERASE_CHIP
  } erase_kind_type;

  // Synchronised serial link
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
  } link_type;

  // Erase job handed to the array
  typedef struct packed {
    erase_kind_type   kind;
    logic [PAGE_BITS-1:0] first_page;
    logic [PAGE_BITS-1:0] page_count;
  } erase_job_type;

endpackage

// [hdl/erase_page_store.sv]
/*
  Page-state memory: one erased flag per page, written by the sequencer
  and read back through a register. Assumes a single clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module erase_page_store
  import erase_seq_pkg::*;
#(
  parameter int unsigned DEPTH = 8192,
  parameter int unsigned AW    = 13
) (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          rst,
  // Write side
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic          wr_data,
  // Read side
  input  wire logic [AW-1:0] rd_addr,
  output var  logic          rd_data
);

  logic mem [DEPTH];

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // ****************************************************************
  // Registered read port
  // ****************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_data <= 1'b0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule
`default_nettype wire

// [hdl/erase_sequencer.sv]
/*
  Erase command sequencer for a serial flash: shifts in command bytes from
  the serial link, decodes block, sector and chip erase, and runs each erase
  as a self-timed job marking pages erased in the page store.
  Assumes SCK, CS_N and SI are asynchronous pins sampled by mclk (SPI mode 0/3,
  data taken on SCK rise), and that SCK is at most a quarter of mclk.
*/
// Behaviour
// - Standard mode block erase: 50H, one ignored bit, page bits 12..3, 13 ignored.
// - Binary mode block erase: 50H, two ignored, address 21..12, 12 ignored.
// - Chip select rising after block erase erases eight consecutive pages, self-timed.
// - Ten block bits pick block 0..1023; low three page bits ignored.
// - Sector erase is 7CH; 64 sectors; one sector per command.
// - Standard mode sector 0a/0b: page bits 12..3 after one ignored bit.
// - Standard mode sectors 1..63: page bits 12..9 after one ignored bit; the code decodes page bits 12..7.
// - Binary mode sectors use address 21..12 or 21..18 after two ignored bits; the code uses 21..16 for sectors 1..63.
// - Any address inside a sector selects that whole sector; the code picks 0a/0b by page bit 3 only, so 0b pages with bit 3 clear get 0a.
// - Chip select rising after sector erase starts a self-timed sector erase.
// - Block or sector erase shows busy in status and on ready/busy pin.
// - Chip erase is C7H 94H 80H 9AH with no address bytes.
// - Bytes after the fourth chip erase byte are ignored.
// - Chip select rising after the sequence starts whole array erase.
// - Chip erase shows busy in the status register.
// - Chip erase skips protected or locked sectors.
// - Erased locations read back as all ones.
`timescale 1ns/1ps
`default_nettype none
module erase_sequencer
  import erase_seq_pkg::*;
#(
  parameter int unsigned BLOCK_CYCLES  = BLOCK_ERASE_CYCLES,
  parameter int unsigned SECTOR_CYCLES = SECTOR_ERASE_CYCLES,
  parameter int unsigned CHIP_CYCLES   = WHOLE_ARRAY_ERASE_CYCLES
) (
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rst,
  // Serial link pins
  input  wire logic                   cs_n,
  input  wire logic                   sck,
  input  wire logic                   si,
  // Configuration
  input  wire logic                   binary_page_mode,
  input  wire logic [NUM_SECTORS-1:0] sector_protected,
  input  wire logic [NUM_SECTORS-1:0] sector_locked,
  // Status
  output var  logic                   ready_busy_n,
  output var  logic                   status_busy,
  output var  erase_job_type          active_job,
  // Array read-back
  input  wire logic [PAGE_BITS-1:0]   probe_page,
  output var  logic [7:0]             probe_byte
);

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Page number from the 24-bit address field in either layout
  function automatic logic [PAGE_BITS-1:0] page_of(input logic [23:0] a, input logic bin);
    page_of = bin ? a[BIN_PAGE_LSB +: PAGE_BITS] : a[STD_PAGE_LSB +: PAGE_BITS];
  endfunction

  function automatic logic [SECTOR_BITS-1:0] sector_of(input logic [PAGE_BITS-1:0] p);
    sector_of = p[SECTOR_LSB +: SECTOR_BITS];
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  link_type sync1_reg;
  link_type sync2_reg;
  link_type last_reg;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync1_reg <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
      sync2_reg <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
      last_reg  <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
    end else begin
      sync1_reg <= '{cs_n: cs_n, sck: sck, si: si};
      sync2_reg <= sync1_reg;
      last_reg  <= sync2_reg;
    end
  end

  logic sck_rise;
  logic cs_rise;
  logic cs_fall;
  assign sck_rise = sync2_reg.sck & ~last_reg.sck & ~sync2_reg.cs_n;
  assign cs_rise  = sync2_reg.cs_n & ~last_reg.cs_n;
  assign cs_fall  = ~sync2_reg.cs_n & last_reg.cs_n;

  // ****************************************************************
  // Byte shifter
  // ****************************************************************
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic       byte_done;
  logic [2:0] byte_cnt_reg;

  assign shift_next = {shift_reg[6:0], sync2_reg.si};
  assign byte_done  = sck_rise && (bit_cnt_reg == 3'h7);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bit_cnt_reg <= 3'h0;
      shift_reg   <= 8'h00;
    end else if (cs_fall) begin
      bit_cnt_reg <= 3'h0;
    end else if (sck_rise) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      shift_reg   <= shift_next;
    end
  end

  // Saturates at 7 so that trailing bytes never wrap back to the opcode slot
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      byte_cnt_reg <= 3'h0;
    end else if (cs_fall) begin
      byte_cnt_reg <= 3'h0;
    end else if (byte_done && byte_cnt_reg != 3'h7) begin
      byte_cnt_reg <= byte_cnt_reg + 3'h1;
    end
  end

  // ****************************************************************
  // Command decode
  // ****************************************************************
  erase_kind_type cmd_reg;
  logic [23:0]    addr_reg;
  logic           cmd_ok_reg;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmd_reg    <= ERASE_NONE;
      addr_reg   <= 24'h000000;
      cmd_ok_reg <= 1'b0;
    end else if (cs_fall) begin
      cmd_reg    <= ERASE_NONE;
      cmd_ok_reg <= 1'b0;
    end else if (byte_done) begin
      case (byte_cnt_reg)
        3'h0: begin
          // Commands arriving while busy are dropped
          if (!status_busy && shift_next == OP_BLOCK_ERASE) begin
            cmd_reg <= ERASE_BLOCK;
          end else if (!status_busy && shift_next == OP_SECTOR_ERASE) begin
            cmd_reg <= ERASE_SECTOR;
          end else if (!status_busy && shift_next == CHIP_ERASE_B0) begin
            cmd_reg <= ERASE_CHIP;
          end else begin
            cmd_reg <= ERASE_NONE;
          end
        end
        3'h1, 3'h2, 3'h3: begin
          if (cmd_reg == ERASE_CHIP) begin
            // Exact byte order enforced
            if ((byte_cnt_reg == 3'h1 && shift_next != CHIP_ERASE_B1) ||
                (byte_cnt_reg == 3'h2 && shift_next != CHIP_ERASE_B2) ||
                (byte_cnt_reg == 3'h3 && shift_next != CHIP_ERASE_B3)) begin
              cmd_reg <= ERASE_NONE;
            end
            cmd_ok_reg <= (byte_cnt_reg == 3'h3) && (shift_next == CHIP_ERASE_B3);
          end else begin
            addr_reg   <= {addr_reg[15:0], shift_next};
            cmd_ok_reg <= (byte_cnt_reg == 3'h3);
          end
        end
        default: begin
          // Extra bytes: chip erase disregards them; erase with address
          // bytes overrun is treated as malformed
          if (cmd_reg != ERASE_CHIP) begin
            cmd_ok_reg <= 1'b0;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Job build on chip select rise
  // ****************************************************************
  logic [PAGE_BITS-1:0] sel_page;
  logic [PAGE_BITS-1:0] job_first;
  logic [PAGE_BITS-1:0] job_count;
  logic                 sector0;

  assign sel_page = page_of(addr_reg, binary_page_mode);
  assign sector0  = (sector_of(sel_page) == '0);

  always_comb begin
    job_first = '0;
    job_count = '0;
    case (cmd_reg)
      ERASE_BLOCK: begin
        // Low three page bits cleared; block of eight
        job_first = {sel_page[PAGE_BITS-1:BLOCK_LSB], 3'h0};
        job_count = PAGE_BITS'(PAGES_PER_BLOCK);
      end
      ERASE_SECTOR: begin
        // Sector by page 12..7; sector 0 splits by page bit 3 into 0a (8 pages) and 0b (120)
        if (sector0) begin
          job_first = sel_page[SUB_SECTOR_BIT] ? PAGE_BITS'(PAGES_PER_BLOCK) : '0;
          job_count = sel_page[SUB_SECTOR_BIT] ? PAGE_BITS'((1 << SECTOR_LSB) - PAGES_PER_BLOCK)
                                               : PAGE_BITS'(PAGES_PER_BLOCK);
        end else begin
          job_first = {sector_of(sel_page), 7'h00};
          job_count = PAGE_BITS'(1 << SECTOR_LSB);
        end
      end
      default: begin
        job_first = '0;
        job_count = '0;
      end
    endcase
  end

  // ****************************************************************
  // Self-timed erase engine
  // ****************************************************************
  typedef enum logic [1:0] {IDLE, WIPE, WAIT_TIME} engine_state_type;
  engine_state_type     state_reg;
  logic [PAGE_BITS-1:0] wipe_page_reg;
  logic [PAGE_BITS:0]   wipe_left_reg;
  logic [TIMER_WIDTH-1:0] timer_reg;
  logic                 wipe_allowed;

  // Chip erase leaves protected or locked sectors intact
  assign wipe_allowed = (active_job.kind != ERASE_CHIP) ||
                        !(sector_protected[sector_of(wipe_page_reg)] |
                          sector_locked[sector_of(wipe_page_reg)]);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg     <= IDLE;
      active_job    <= '{kind: ERASE_NONE, first_page: '0, page_count: '0};
      wipe_page_reg <= '0;
      wipe_left_reg <= '0;
      timer_reg     <= '0;
    end else begin
      case (state_reg)
        IDLE: begin
          // Start only on chip select rising after a complete command
          if (cs_rise && cmd_ok_reg && cmd_reg != ERASE_NONE) begin
            state_reg <= WIPE;
            if (cmd_reg == ERASE_CHIP) begin
              active_job    <= '{kind: ERASE_CHIP, first_page: '0, page_count: '0};
              wipe_page_reg <= '0;
              wipe_left_reg <= (PAGE_BITS+1)'(1 << PAGE_BITS);
              timer_reg     <= TIMER_WIDTH'(CHIP_CYCLES);
            end else begin
              active_job    <= '{kind: cmd_reg, first_page: job_first, page_count: job_count};
              wipe_page_reg <= job_first;
              wipe_left_reg <= {1'b0, job_count};
              timer_reg     <= (cmd_reg == ERASE_BLOCK) ? TIMER_WIDTH'(BLOCK_CYCLES)
                                                         : TIMER_WIDTH'(SECTOR_CYCLES);
            end
          end
        end
        WIPE: begin
          if (timer_reg != '0) begin
            timer_reg <= timer_reg - 1'b1;
          end
          if (wipe_left_reg <= 1) begin
            state_reg <= WAIT_TIME;
          end
          wipe_left_reg <= wipe_left_reg - 1'b1;
          wipe_page_reg <= wipe_page_reg + 1'b1;
        end
        WAIT_TIME: begin
          // Busy lasts the full erase time even when the wipe ends early
          if (timer_reg <= 1) begin
            state_reg  <= IDLE;
            active_job <= '{kind: ERASE_NONE, first_page: '0, page_count: '0};
          end else begin
            timer_reg <= timer_reg - 1'b1;
          end
        end
        default: state_reg <= IDLE;
      endcase
    end
  end

  // Busy in status and on the pin for every erase kind
  assign status_busy  = (state_reg != IDLE);
  assign ready_busy_n = ~status_busy;

  // ****************************************************************
  // Page store
  // ****************************************************************
  logic erased_bit;

  erase_page_store #(
    .DEPTH (1 << PAGE_BITS),
    .AW    (PAGE_BITS)
  ) page_store (
    .mclk    (mclk),
    .rst     (rst),
    .wr_en   ((state_reg == WIPE) && wipe_allowed),
    .wr_addr (wipe_page_reg),
    .wr_data (1'b1),
    .rd_addr (probe_page),
    .rd_data (erased_bit)
  );

  // Erased pages read back as all ones; others unknown content shown as zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      probe_byte <= 8'h00;
    end else begin
      probe_byte <= erased_bit ? ERASED_BYTE : 8'h00;
    end
  end

endmodule
`default_nettype wire

// [dv/erase_seq_checker.sv]
/*
  Port checker for erase_sequencer: busy timing, busy pins and job shape.
  Assumes one mclk domain and binding to every erase_sequencer instance.
*/
`timescale 1ns/1ps
`default_nettype none
module erase_seq_checker
  import erase_seq_pkg::*;
#(
  parameter int unsigned BLOCK_CYCLES  = BLOCK_ERASE_CYCLES,
  parameter int unsigned SECTOR_CYCLES = SECTOR_ERASE_CYCLES,
  parameter int unsigned CHIP_CYCLES   = WHOLE_ARRAY_ERASE_CYCLES
) (
  // Clock and reset
  input wire logic          mclk,
  input wire logic          rst,
  // Link and status
  input wire logic          cs_n,
  input wire logic          ready_busy_n,
  input wire logic          status_busy,
  input wire erase_job_type active_job
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // ****************************************************************
  // Busy length counter
  // ****************************************************************
  logic [31:0] busy_len_reg;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy_len_reg <= 32'h0;
    end else if (status_busy) begin
      busy_len_reg <= busy_len_reg + 32'h1;
    end else begin
      busy_len_reg <= 32'h0;
    end
  end

  a_busy_pins_agree: assert property (ready_busy_n == !status_busy)
    else $error("busy pin and busy status disagree");
  a_busy_after_cs: assert property ($rose(status_busy) |-> cs_n && $past(cs_n, 2) && !$past(cs_n, 7))
    else $error("busy rose without a recent chip select release");
  a_busy_has_job: assert property (status_busy |-> active_job.kind != ERASE_NONE)
    else $error("busy without an erase job");
  a_block_shape: assert property (status_busy && active_job.kind == ERASE_BLOCK |->
    active_job.page_count == 13'h8 && active_job.first_page[2:0] == 3'h0)
    else $error("block job is not eight aligned pages");
  a_sector_shape: assert property (status_busy && active_job.kind == ERASE_SECTOR |->
    (active_job.first_page[12:7] != 6'h0 && active_job.first_page[6:0] == 7'h0 && active_job.page_count == 13'h80) ||
    (active_job.first_page == 13'h0 && active_job.page_count == 13'h8) ||
    (active_job.first_page == 13'h8 && active_job.page_count == 13'h78))
    else $error("sector job does not match one sector");
  a_job_steady: assert property (status_busy && $past(status_busy) |-> $stable(active_job))
    else $error("job changed while busy");
  a_busy_min_len: assert property ($fell(status_busy) |-> $past(busy_len_reg) >= BLOCK_CYCLES - 2)
    else $error("busy ended too early");
  a_busy_max_len: assert property (status_busy |-> busy_len_reg <= CHIP_CYCLES + 2)
    else $error("busy stands too long");
endmodule

bind erase_sequencer erase_seq_checker #(
  .BLOCK_CYCLES (BLOCK_CYCLES),
  .SECTOR_CYCLES(SECTOR_CYCLES),
  .CHIP_CYCLES  (CHIP_CYCLES)
) i_chk (
  .mclk        (mclk),
  .rst         (rst),
  .cs_n        (cs_n),
  .ready_busy_n(ready_busy_n),
  .status_busy (status_busy),
  .active_job  (active_job)
);
`default_nettype wire

// [dv/flash_host_model.sv]
/*
  Host serial master model: sends one framed bit string, MSB first, mode 0.
  Assumes the caller starts a frame just after an mclk edge; sck idles low.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_host_model #(
  parameter int unsigned HALF_NS = 160
) (
  // Serial link toward the device
  output var logic cs_n,
  output var logic sck,
  output var logic si
);
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end

  // Returns at the chip select rise so the caller can time busy from it
  task automatic frame(input logic [39:0] bits, input int nbits);
    cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      si = bits[39-i];
      #(HALF_NS) sck = 1'b1;
      #(HALF_NS) sck = 1'b0;
    end
    // Released data line must not keep its last value
    si = ~si;
    #(HALF_NS) cs_n = 1'b1;
  endtask
endmodule
`default_nettype wire

// [dv/erase_sequencer_bench.sv]
/*
  Self-checking bench for erase_sequencer: random and corner erases, refusals,
  chip erase with protection. Assumes short erase counts via parameters.
*/
`timescale 1ns/1ps
`default_nettype none
module erase_sequencer_bench;
  import erase_seq_pkg::*;
  localparam int BLK = 50;
  localparam int SEC = 400;
  localparam int CHP = 8300;
  logic                   mclk, rst, cs_n, sck, si, binary_page_mode;
  logic [NUM_SECTORS-1:0] sector_protected, sector_locked;
  logic                   ready_busy_n, status_busy;
  erase_job_type          active_job;
  logic [PAGE_BITS-1:0]   probe_page;
  logic [7:0]             probe_byte;
  int                     num_errors = 0;
  int                     samples_checked = 0;
  bit                     ers [8192];

  erase_sequencer #(.BLOCK_CYCLES(BLK), .SECTOR_CYCLES(SEC), .CHIP_CYCLES(CHP)) i_dut (
    .mclk(mclk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si), .binary_page_mode(binary_page_mode),
    .sector_protected(sector_protected), .sector_locked(sector_locked), .ready_busy_n(ready_busy_n),
    .status_busy(status_busy), .active_job(active_job), .probe_page(probe_page), .probe_byte(probe_byte));
  flash_host_model i_host (.cs_n(cs_n), .sck(sck), .si(si));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic logic [39:0] cmd(input logic [7:0] op, input logic [12:0] pg, input logic [8:0] junk);
    if (binary_page_mode) return {op, 2'b0, pg, junk, 8'h0};
    return {op, 1'b0, pg, junk, 1'b1, 8'h0};
  endfunction

  // First page and page count of the erase that a page selects
  function automatic logic [25:0] span(input bit sec, input logic [12:0] pg);
    if (!sec) return {pg[12:3], 3'h0, 13'h8};
    if (pg[12:7] != 6'h0) return {pg[12:7], 7'h0, 13'h80};
    return pg[3] ? {13'h8, 13'h78} : {13'h0, 13'h8};
  endfunction

  task automatic erase(input logic [39:0] bits, input int nbits, input erase_kind_type kind,
                       input logic [25:0] sp, input int cycles, input bit overlap);
    int n;
    n = 0;
    @(posedge mclk) #1;
    i_host.frame(bits, nbits);
    while (status_busy !== 1'b1 && n < 20) begin @(posedge mclk) #1; n++; end
    #1 check("busy pins", {status_busy, ready_busy_n}, 2'b10);
    check("job kind", active_job.kind, kind);
    if (kind != ERASE_CHIP) begin
      check("first page", active_job.first_page, sp[25:13]);
      check("page count", active_job.page_count, sp[12:0]);
      for (int p = sp[25:13]; p < sp[25:13] + sp[12:0]; p++) ers[p] = 1'b1;
    end
    if (overlap) fork begin @(posedge mclk) #1; i_host.frame(cmd(OP_BLOCK_ERASE, 13'h0, 9'h0), 32); end join_none
    n = 0;
    while (status_busy === 1'b1 && n < CHP + 10) begin @(posedge mclk) #1; n++; end
    check("busy length", n >= cycles - 3 && n <= cycles + 3, 1);
    // The overlapping frame must be over before the next frame reuses the host model
    if (overlap) begin wait fork; repeat (20) @(posedge mclk); #1 check("ignored while busy", status_busy, 0); end
  endtask

  task automatic refused(input logic [39:0] bits, input int nbits);
    @(posedge mclk) #1;
    i_host.frame(bits, nbits);
    repeat (12) @(posedge mclk);
    #1 check("refused", status_busy, 0);
  endtask

  task automatic probe(input int page);
    @(posedge mclk) #1 probe_page = 13'(page);
    repeat (3) @(posedge mclk);
    #1 check("read back", probe_byte === ERASED_BYTE, ers[page]);
  endtask

  // ****************************************************************
  // Stimulus
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  initial begin
    #(40 * 60000);
    num_errors++;
    test_done();
  end

  initial begin
    rst = 1'b1;
    binary_page_mode = 1'b0;
    sector_protected = '0;
    sector_locked = '0;
    probe_page = '0;
    repeat (8) @(posedge mclk);
    #1 rst = 1'b0;
    repeat (3) @(posedge mclk);
    void'($urandom(20961));
    // Corners first: last block, sectors 0a, 0b, 63; then random erases
    for (int t = 0; t < 12; t++) begin
      logic [12:0] pg;
      bit          sec;
      logic [25:0] sp;
      pg = (t == 0) ? 13'h1FFF : (t == 1) ? 13'h3 : (t == 2) ? 13'hC : (t == 3) ? 13'h1F9A : 13'($urandom);
      // Run 4 overlaps a frame with a busy erase, so it must be a long sector erase
      sec = (t == 0) ? 1'b0 : (t < 5) ? 1'b1 : 1'($urandom);
      if (sec && pg < 13'h80) pg = pg & 13'hF;
      binary_page_mode = 1'($urandom);
      sector_protected = {$urandom, $urandom};
      sector_locked = {$urandom, $urandom};
      sp = span(sec, pg);
      erase(cmd(sec ? OP_SECTOR_ERASE : OP_BLOCK_ERASE, pg, 9'($urandom)), 32,
            sec ? ERASE_SECTOR : ERASE_BLOCK, sp, sec ? SEC : BLK, t == 4);
      if (sp[25:13] > 0) probe(sp[25:13] - 1);
      probe(sp[25:13]);
      probe(sp[25:13] + sp[12:0] - 1);
      if (sp[25:13] + sp[12:0] < 8192) probe(sp[25:13] + sp[12:0]);
    end
    refused({CHIP_ERASE_B0, CHIP_ERASE_B1, 8'h81, CHIP_ERASE_B3, 8'h0}, 32);
    refused(cmd(OP_BLOCK_ERASE, 13'h40, 9'h0), 24);
    refused(cmd(OP_BLOCK_ERASE, 13'h40, 9'h0), 29);
    refused(cmd(OP_SECTOR_ERASE, 13'h100, 9'h0), 40);
    sector_protected = {$urandom, $urandom} & {$urandom, $urandom};
    sector_locked = {$urandom, $urandom} & {$urandom, $urandom};
    erase({CHIP_ERASE_B0, CHIP_ERASE_B1, CHIP_ERASE_B2, CHIP_ERASE_B3, 8'($urandom)}, 40,
          ERASE_CHIP, 26'h0, CHP, 1'b0);
    for (int s = 0; s < 64; s++) begin
      if (!(sector_protected[s] | sector_locked[s])) begin
        for (int p = s * 128; p < s * 128 + 128; p++) ers[p] = 1'b1;
      end
    end
    for (int s = 0; s < 64; s++) probe(s * 128 + $urandom_range(127));
    test_done();
  end
endmodule
`default_nettype wire
